// [rtl/hsc_pkg.sv]
package hsc_pkg;

  // core clock
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // capture serial clock rates and the resulting core cycles per bit
  localparam int unsigned SCLK_FAST_HZ = 8_000_000;
  localparam int unsigned SCLK_SLOW_HZ = 4_000_000;
  localparam logic [3:0] DIV_FAST = 4'(CLK_HZ / SCLK_FAST_HZ);
  localparam logic [3:0] DIV_SLOW = 4'(CLK_HZ / SCLK_SLOW_HZ);

  // pause between packages, in capture clock cycles
  localparam logic [3:0] GAP_SCLK_CYCLES = 4'h7;

  // waveform sample period
  localparam int unsigned SAMPLE_PERIOD_NS = 125_000;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // capture_port_config field positions and reset value
  localparam int unsigned CFG_CLK_SLOW_BIT = 0;
  localparam int unsigned CFG_SIZE8_BIT = 1;
  localparam int unsigned CFG_GAP_BIT = 2;
  localparam int unsigned CFG_SET_LSB = 3;
  localparam int unsigned CFG_POL_BIT = 5;
  localparam logic [7:0] CFG_USED_MASK = 8'h3F;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // word geometry
  localparam int unsigned NUM_WORDS = 16;
  localparam int unsigned SRC_W = 24;
  localparam int unsigned WORD_W = 32;

  // slot map: 0..5 phase samples, 6 neutral, 7..15 powers
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_NEUTRAL = 4'h6;
  localparam logic [3:0] SLOT_POWER_FIRST = 4'h7;
  localparam logic [3:0] SLOT_REACT_FIRST = 4'hD;

  // word-set codes
  localparam logic [1:0] SET_ALL = 2'h0;
  localparam logic [1:0] SET_WAVE = 2'h1;
  localparam logic [1:0] SET_POWER = 2'h2;
  localparam logic [1:0] SET_RESERVED = 2'h3;

  // words per set, minus one
  localparam logic [3:0] ALL_LAST = 4'hF;
  localparam logic [3:0] WAVE_LAST = 4'h6;
  localparam logic [3:0] POWER_LAST = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP} hsc_state_t;

  function automatic logic [3:0] hsc_first_slot(input logic [1:0] set);
    hsc_first_slot = (set == SET_POWER) ? SLOT_POWER_FIRST : SLOT_FIRST;
  endfunction : hsc_first_slot

  function automatic logic [3:0] hsc_words_last(input logic [1:0] set);
    unique case (set)
      SET_WAVE: hsc_words_last = WAVE_LAST;
      SET_POWER: hsc_words_last = POWER_LAST;
      default: hsc_words_last = ALL_LAST;
    endcase
  endfunction : hsc_words_last

endpackage : hsc_pkg

// [rtl/hsc_word_if.sv]
`timescale 1ns/1ps
interface hsc_word_if;
  logic [3:0] slot;
  logic [31:0] word;

  modport requester (output slot, input word);
  modport provider (input slot, output word);
endinterface : hsc_word_if

// [rtl/hsc_word_mux.sv]
`timescale 1ns/1ps
module hsc_word_mux
  import hsc_pkg::*;
#(
  parameter bit HAS_NEUTRAL = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  // source registers, slot 0 in the low bits
  input wire logic [NUM_WORDS*SRC_W-1:0] i_source_words,
  // word lookup
  hsc_word_if.provider bus
);

  function automatic logic [WORD_W-1:0] sign_extend(input logic [SRC_W-1:0] v);
    sign_extend = {{(WORD_W - SRC_W){v[SRC_W-1]}}, v};
  endfunction : sign_extend

  wire logic [SRC_W-1:0] raw;
  wire logic absent;

  assign raw = i_source_words[bus.slot * SRC_W +: SRC_W];
  // missing registers still occupy their slot so receivers keep a fixed frame
  assign absent = (!HAS_NEUTRAL && bus.slot == SLOT_NEUTRAL) ||
                  (!HAS_REACTIVE && bus.slot >= SLOT_REACT_FIRST);
  assign bus.word = absent ? 32'h0000_0000 : sign_extend(raw);

endmodule : hsc_word_mux

// [rtl/hsc_capture_tx.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - port stays off after reset; runs only when the enable bit is one
// - enable ignored while the host link is SPI; works only with I2C
// - every word from a present register is its 24-bit source sign-extended to 32 bits
// - full set: six phase samples, neutral, apparent, active, reactive powers
// - missing neutral or reactive registers send zero words in their slots
// - port is always master: makes serial clock, drives select and data
// - after reset data and select pins are driven high
// - serial clock 8 MHz when config bit 0 clear, 4 MHz when set
// - data changes on clock falling edge; receiver samples on rising edge
// - packages are 32 bits with config bit 1 clear, 8 bits when set
// - each word leaves most significant bit first
// - config bit 2 adds seven clock cycle gaps between packages
// - bits 4:3 pick all sixteen, seven waveform, or nine power words
// - word-set code 11 behaves as code 00
// - bit 5 sets select polarity; select idles during gaps
// - config bits 7:6 are ignored
// - burst each 125 us period; overlong bursts use every second period
// - burst length follows bit, gap and package timing exactly
// - config registers are written by the host slave interface
module hsc_capture_tx
  import hsc_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD_CYCLES = SAMPLE_CYCLES,
  parameter bit HAS_NEUTRAL = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register access from the host slave interface
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_port_enable,
  input wire logic i_host_is_spi,
  // waveform and power source registers, slot 0 in the low bits
  input wire logic [NUM_WORDS*SRC_W-1:0] i_source_words,
  // capture link pins
  output logic o_capture_select_line,
  output logic o_capture_data_line,
  output logic o_capture_serial_clock,
  // status
  output logic o_port_active,
  output logic o_burst_active
);

  // reset release
  logic [1:0] rst_pipe;
  wire logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // configuration register
  logic [7:0] cfg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (i_cfg_write) begin
      cfg <= i_cfg_wdata & CFG_USED_MASK;
    end
  end

  assign o_cfg_rdata = cfg;

  wire logic port_on;
  wire logic [1:0] live_set;

  assign port_on = i_port_enable && !i_host_is_spi;
  // reserved code folds onto the full set
  assign live_set = (cfg[CFG_SET_LSB +: 2] == SET_RESERVED) ? SET_ALL : cfg[CFG_SET_LSB +: 2];

  // waveform sample period
  logic [12:0] period_cnt;
  wire logic period_tick;

  assign period_tick = (period_cnt == 13'(SAMPLE_PERIOD_CYCLES - 1));

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= 13'h0000;
    end else if (period_tick) begin
      period_cnt <= 13'h0000;
    end else begin
      period_cnt <= period_cnt + 13'h0001;
    end
  end

  // word lookup
  hsc_word_if word_bus ();

  hsc_word_mux #(
    .HAS_NEUTRAL(HAS_NEUTRAL),
    .HAS_REACTIVE(HAS_REACTIVE)
  ) u_word_mux (
    .i_source_words(i_source_words),
    .bus(word_bus.provider)
  );

  // sequencer state
  hsc_state_t state;
  logic lat_slow;
  logic lat_size8;
  logic lat_gap;
  logic lat_pol;
  logic [3:0] rd_slot;
  logic [3:0] words_left;
  logic [31:0] shreg;
  logic [3:0] phase;
  logic [4:0] bit_idx;
  logic [6:0] gap_cnt;

  assign word_bus.slot = rd_slot;

  // bit timing
  wire logic [3:0] div;
  wire logic [3:0] low_len;
  wire logic bit_end;
  wire logic word_end;
  wire logic pkg_end;
  wire logic burst_end;
  wire logic gap_done;
  wire logic [6:0] gap_len;
  wire logic start_burst;
  wire logic sel_active;
  wire logic sel_idle;

  assign div = lat_slow ? DIV_SLOW : DIV_FAST;
  // odd divisor: clock spends the extra cycle low
  assign low_len = div - (div >> 1);
  assign bit_end = (state == ST_SHIFT) && (phase == div - 4'h1);
  assign word_end = bit_end && (bit_idx == 5'h1F);
  assign pkg_end = bit_end && (lat_size8 ? (bit_idx[2:0] == 3'h7) : word_end);
  assign burst_end = word_end && (words_left == 4'h0);
  // widen before the product so the slow gap of 70 cycles is not cut to four bits
  assign gap_len = 7'(GAP_SCLK_CYCLES) * 7'(div);
  assign gap_done = (state == ST_GAP) && (gap_cnt == gap_len - 7'h01);
  // a tick that finds a burst still running is skipped
  assign start_burst = port_on && period_tick && (state == ST_IDLE);
  assign sel_active = lat_pol;
  assign sel_idle = ~lat_pol;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!port_on) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: state <= start_burst ? ST_LOAD : ST_IDLE;
        ST_LOAD: state <= ST_SHIFT;
        ST_SHIFT: begin
          if (burst_end) begin
            state <= ST_IDLE;
          end else if (pkg_end && lat_gap) begin
            state <= ST_GAP;
          end
        end
        ST_GAP: state <= gap_done ? ST_SHIFT : ST_GAP;
      endcase
    end
  end

  // settings latched at burst start
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_slow <= 1'b0;
      lat_size8 <= 1'b0;
      lat_gap <= 1'b0;
      lat_pol <= 1'b0;
    end else if (start_burst) begin
      lat_slow <= cfg[CFG_CLK_SLOW_BIT];
      lat_size8 <= cfg[CFG_SIZE8_BIT];
      lat_gap <= cfg[CFG_GAP_BIT];
      lat_pol <= cfg[CFG_POL_BIT];
    end
  end

  // word walk: rd_slot always points at the next word to load
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_slot <= SLOT_FIRST;
      words_left <= 4'h0;
    end else if (start_burst) begin
      rd_slot <= hsc_first_slot(live_set);
      words_left <= hsc_words_last(live_set);
    end else if (state == ST_LOAD || (word_end && !burst_end)) begin
      rd_slot <= rd_slot + 4'h1;
      words_left <= (state == ST_LOAD) ? words_left : words_left - 4'h1;
    end
  end

  // shifter
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 32'h0000_0000;
    end else if (state == ST_LOAD || word_end) begin
      shreg <= word_bus.word;
    end else if (bit_end) begin
      shreg <= {shreg[30:0], 1'b0};
    end
  end

  // bit phase and bit index
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 4'h0;
      bit_idx <= 5'h00;
    end else if (state != ST_SHIFT) begin
      phase <= 4'h0;
      bit_idx <= (state == ST_GAP) ? bit_idx : 5'h00;
    end else if (bit_end) begin
      phase <= 4'h0;
      bit_idx <= bit_idx + 5'h01;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // gap timer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 7'h00;
    end else if (state == ST_GAP) begin
      gap_cnt <= gap_cnt + 7'h01;
    end else begin
      gap_cnt <= 7'h00;
    end
  end

  // pin drivers
  logic next_sel;
  logic next_data;
  logic next_sclk;

  always_comb begin
    next_sel = o_capture_select_line;
    next_data = o_capture_data_line;
    next_sclk = o_capture_serial_clock;
    if (!port_on) begin
      // pins stay high while the port is off
      next_sel = 1'b1;
      next_data = 1'b1;
      next_sclk = 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sel = ~cfg[CFG_POL_BIT];
          next_data = 1'b1;
          next_sclk = 1'b1;
        end
        ST_LOAD: begin
          next_sel = sel_active;
        end
        ST_SHIFT: begin
          if (burst_end) begin
            next_sel = sel_idle;
            next_data = 1'b1;
            next_sclk = 1'b1;
          end else if (pkg_end && lat_gap) begin
            next_sel = sel_idle;
            next_sclk = 1'b1;
          end else if (phase == 4'h0) begin
            next_sclk = 1'b0;
            next_data = shreg[31];
          end else if (phase == low_len) begin
            next_sclk = 1'b1;
          end
        end
        ST_GAP: begin
          next_sel = gap_done ? sel_active : sel_idle;
          next_sclk = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_capture_select_line <= 1'b1;
      o_capture_data_line <= 1'b1;
      o_capture_serial_clock <= 1'b1;
    end else begin
      o_capture_select_line <= next_sel;
      o_capture_data_line <= next_data;
      o_capture_serial_clock <= next_sclk;
    end
  end

  // status
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_port_active <= 1'b0;
      o_burst_active <= 1'b0;
    end else begin
      o_port_active <= port_on;
      o_burst_active <= port_on && (start_burst || (state != ST_IDLE && !burst_end));
    end
  end

endmodule : hsc_capture_tx

// [tb/hsc_capture_tx_checker.sv]
`timescale 1ns/1ps
module hsc_capture_tx_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register and control inputs
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_port_enable,
  input wire logic i_host_is_spi,
  // outputs watched
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_capture_select_line,
  input wire logic o_capture_data_line,
  input wire logic o_capture_serial_clock,
  input wire logic o_port_active,
  input wire logic o_burst_active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // bench never writes during the latch cycle, so readback equals the latched set
  logic [7:0] cfg_l;
  always_ff @(posedge i_clk) begin
    if ($rose(o_burst_active)) begin
      cfg_l <= o_cfg_rdata;
    end
  end

  sequence s_fast_bit;
    !o_capture_serial_clock [*3] ##1 o_capture_serial_clock [*2];
  endsequence
  sequence s_slow_bit;
    !o_capture_serial_clock [*5] ##1 o_capture_serial_clock [*5];
  endsequence
  sequence s_burst_open;
    ##1 (o_capture_select_line == cfg_l[5]) ##1 $fell(o_capture_serial_clock);
  endsequence

  a_cfg_mask: assert property (
    i_cfg_write |=> o_cfg_rdata == ($past(i_cfg_wdata) & 8'h3F)) else $error("config readback wrong");
  a_off_pins_high: assert property (
    (!i_port_enable || i_host_is_spi) [*3] |->
    (o_capture_select_line && o_capture_data_line && o_capture_serial_clock)) else $error("pins not high when off");
  a_data_on_fall: assert property (
    (o_burst_active && i_port_enable && $stable(o_capture_select_line) && $changed(o_capture_data_line))
    |-> $fell(o_capture_serial_clock)) else $error("data moved off a clock fall");
  a_sclk_idle: assert property (
    !o_burst_active |-> o_capture_serial_clock) else $error("serial clock low outside burst");
  a_fast_bit: assert property (
    ($fell(o_capture_serial_clock) && !cfg_l[0]) |-> s_fast_bit) else $error("fast bit timing wrong");
  a_slow_bit: assert property (
    ($fell(o_capture_serial_clock) && cfg_l[0]) |-> s_slow_bit) else $error("slow bit timing wrong");
  a_burst_open: assert property (
    $rose(o_burst_active) |-> s_burst_open) else $error("burst start sequence wrong");
  a_sel_on_rise: assert property (
    (o_burst_active && $rose(o_capture_serial_clock)) |-> o_capture_select_line == cfg_l[5])
    else $error("select inactive at sampling edge");
  a_idle_sel: assert property (
    ($stable(o_cfg_rdata) && !o_burst_active && o_port_active) [*3] |->
    o_capture_select_line != o_cfg_rdata[5]) else $error("select idle level wrong");
endmodule : hsc_capture_tx_checker

bind hsc_capture_tx hsc_capture_tx_checker u_hsc_capture_tx_checker (.i_clk, .i_resetn, .i_cfg_write,
  .i_cfg_wdata, .i_port_enable, .i_host_is_spi, .o_cfg_rdata, .o_capture_select_line,
  .o_capture_data_line, .o_capture_serial_clock, .o_port_active, .o_burst_active);

// [tb/hsc_rx_model.sv]
`timescale 1ns/1ps
module hsc_rx_model (
  // capture link as the receiving slave sees it
  input wire logic i_sclk,
  input wire logic i_sel,
  input wire logic i_data,
  // active select level
  input wire logic i_pol
);
  logic [31:0] q[$];
  logic [31:0] sr;
  int n;
  initial n = 0;
  // shifts only while selected, so gap and idle clock edges are ignored
  always @(posedge i_sclk) begin
    if (i_sel === i_pol) begin
      sr = {sr[30:0], i_data};
      n++;
      if (n % 32 == 0) begin
        q.push_back(sr);
      end
    end
  end
endmodule : hsc_rx_model

// [tb/tb_hsc_capture_tx.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_hsc_capture_tx;
  import hsc_pkg::*;
  logic i_clk, i_resetn, i_cfg_write, i_port_enable, i_host_is_spi, pol;
  logic [7:0] i_cfg_wdata, o_cfg_rdata;
  logic [NUM_WORDS*SRC_W-1:0] i_source_words;
  logic o_sel, o_data, o_sclk, o_port_active, o_burst_active;
  logic o_sel_l, o_data_l, o_sclk_l;
  logic [23:0] src [16];
  int error_cnt, n_checks, blen, cyc;

  hsc_capture_tx #(.SAMPLE_PERIOD_CYCLES(6000)) u_hsc_capture_tx (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cfg_write(i_cfg_write), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .i_port_enable(i_port_enable), .i_host_is_spi(i_host_is_spi), .i_source_words(i_source_words),
    .o_capture_select_line(o_sel), .o_capture_data_line(o_data), .o_capture_serial_clock(o_sclk),
    .o_port_active(o_port_active), .o_burst_active(o_burst_active));
  hsc_rx_model u_hsc_rx_model (.i_sclk(o_sclk), .i_sel(o_sel), .i_data(o_data), .i_pol(pol));
  // variant without neutral and reactive registers runs beside the full one
  hsc_capture_tx #(.SAMPLE_PERIOD_CYCLES(6000), .HAS_NEUTRAL(1'b0), .HAS_REACTIVE(1'b0)) u_hsc_capture_tx_lite (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cfg_write(i_cfg_write), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(),
    .i_port_enable(i_port_enable), .i_host_is_spi(i_host_is_spi), .i_source_words(i_source_words),
    .o_capture_select_line(o_sel_l), .o_capture_data_line(o_data_l), .o_capture_serial_clock(o_sclk_l),
    .o_port_active(), .o_burst_active());
  hsc_rx_model u_hsc_rx_model_lite (.i_sclk(o_sclk_l), .i_sel(o_sel_l), .i_data(o_data_l), .i_pol(pol));

  // counted on the falling edge so tasks woken by a rising edge read it without a race
  always @(negedge i_clk) begin
    cyc++;
  end

  always @(posedge i_clk) begin
    if (o_burst_active) begin
      blen++;
    end
  end

  function automatic logic [31:0] exp_word(input int s);
    return {{8{src[s][23]}}, src[s]};
  endfunction : exp_word

  function automatic logic [31:0] exp_lite(input int s);
    return (s == 6 || s >= 13) ? 32'h0000_0000 : exp_word(s);
  endfunction : exp_lite

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic wait_for(input logic lvl);
    int k;
    k = 0;
    while (o_burst_active !== lvl) begin
      @(posedge i_clk);
      k++;
      if (k > 20000) begin
        error_cnt++;
        close_out();
      end
    end
  endtask : wait_for

  task automatic wr(input logic [7:0] v);
    @(posedge i_clk);
    i_cfg_write <= 1'b1;
    i_cfg_wdata <= v;
    @(posedge i_clk);
    i_cfg_write <= 1'b0;
    @(negedge i_clk);
  endtask : wr

  // c2 lands just after the burst has latched c
  task automatic run_burst(input logic [7:0] c, input logic [7:0] c2, input int n, input int first);
    int i;
    wr(c);
    pol = c[5];
    u_hsc_rx_model.q.delete();
    u_hsc_rx_model.n = 0;
    u_hsc_rx_model_lite.q.delete();
    u_hsc_rx_model_lite.n = 0;
    @(posedge i_clk);
    blen = 0;
    i_port_enable <= 1'b1;
    wait_for(1'b1);
    wr(c2);
    wait_for(1'b0);
    i_port_enable <= 1'b0;
    `CHK(u_hsc_rx_model.q.size(), n)
    `CHK(u_hsc_rx_model_lite.q.size(), n)
    for (i = 0; i < n; i++) begin
      `CHK(u_hsc_rx_model.q[i], exp_word(first + i))
      `CHK(u_hsc_rx_model_lite.q[i], exp_lite(first + i))
    end
  endtask : run_burst

  task automatic t_reset;
    `CHK({o_sel, o_data, o_sclk}, 3'b111)
    `CHK({o_port_active, o_burst_active, o_cfg_rdata}, 10'h000)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_mask;
    wr(8'hFF);
    `CHK(o_cfg_rdata, 8'h3F)
    $display("t_mask done");
  endtask : t_mask

  task automatic t_spi;
    @(posedge i_clk);
    blen = 0;
    i_host_is_spi <= 1'b1;
    i_port_enable <= 1'b1;
    repeat (6100) @(posedge i_clk);
    `CHK(blen, 0)
    `CHK({o_port_active, o_sel, o_data, o_sclk}, 4'b0111)
    i_port_enable <= 1'b0;
    i_host_is_spi <= 1'b0;
    $display("t_spi done");
  endtask : t_spi

  task automatic t_full;
    run_burst(8'h00, 8'h00, 16, 0);
    `CHK(blen >= 2560 && blen <= 2570, 1'b1)
    run_burst(8'h04, 8'h04, 16, 0);
    `CHK(blen >= 3085 && blen <= 3125, 1'b1)
    $display("t_full done");
  endtask : t_full

  task automatic t_sets;
    run_burst(8'h0F, 8'h0F, 7, 0);
    run_burst(8'h36, 8'h36, 9, 7);
    run_burst(8'hD9, 8'hD9, 16, 0);
    $display("t_sets done");
  endtask : t_sets

  task automatic t_latch;
    run_burst(8'h00, 8'h35, 16, 0);
    $display("t_latch done");
  endtask : t_latch

  task automatic t_rate;
    int c0, c1;
    wr(8'h07);
    pol = 1'b0;
    @(posedge i_clk);
    i_port_enable <= 1'b1;
    wait_for(1'b1);
    c0 = cyc;
    wait_for(1'b0);
    c1 = cyc;
    `CHK(c1 - c0 >= 9530 && c1 - c0 <= 9540, 1'b1)
    wait_for(1'b1);
    `CHK(cyc - c0, 12000)
    // drop the enable on a bit boundary so the bit timing checks see whole bits
    repeat (200) @(posedge i_clk);
    i_port_enable <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    `CHK({o_sel, o_data, o_sclk, o_burst_active}, 4'b1110)
    $display("t_rate done");
  endtask : t_rate

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    blen = 0;
    pol = 1'b0;
    i_resetn = 1'b0;
    i_cfg_write = 1'b0;
    i_cfg_wdata = 8'h00;
    i_port_enable = 1'b0;
    i_host_is_spi = 1'b0;
    // odd slots negative so sign extension shows both ways
    for (int k = 0; k < 16; k++) begin
      src[k] = {k[0] ? 8'hA5 : 8'h3C, 4'(k), 12'h9E1};
      i_source_words[24*k +: 24] = src[k];
    end
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    t_reset();
    t_mask();
    t_spi();
    t_full();
    t_sets();
    t_latch();
    t_rate();
    close_out();
  end
endmodule : tb_hsc_capture_tx
